/* design/dadc_out.sv */
/*
 * Output side of a dual 12-bit sampling converter: pipeline, DDR lanes,
 * forwarded clock with phase and polarity control, register port.
 * Assumes sample_clock_pos is the link clock of its own domain and that
 * signed 13-bit analog estimates arrive synchronous to it. The fast
 * phase clock runs at eight times the sample rate, and the sample clock
 * is derived from it, so each phase cycle is a 45 degree step of the
 * output clock; the time model is digital only.
 */
`include "dadc_regs.svh"
module dadc_out
    import dadc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              sample_clock_pos,
    input  wire logic              phase_clk,
    input  wire logic signed [12:0] ain_a,
    input  wire logic signed [12:0] ain_b,
    input  wire logic              config_mode_select,
    input  wire logic              par_stab_pin,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    output dadc_lanes_s            lanes,
    output logic                   data_output_clock,
    output logic [3:0]             drive_current_code,
    output logic                   term_enable
);
    logic [7:0]  clock_config_register;
    logic [7:0]  output_config_register;
    logic        mode_s1, mode_s2, pin_s1, pin_s2;
    logic        stab_on;
    logic [1:0]  lk_s1, lk_s2;
    logic [1:0]  lk_cfg;
    logic        lk_stab_s1, lk_stab_s2;
    dadc_word_s  pipe [0:`DADC_PIPE_CYCLES-1];
    dadc_word_s  out_word;
    logic        half;
    logic [1:0]  ph_sel;
    logic        inv_s1, inv_s2;
    logic [2:0]  ph_delay;
    logic        ovr_seen;
    logic        ovr_t_s1, ovr_t_s2, ovr_t_s3;
    logic        ovr_toggle;
    logic        sticky_ovr;
    logic        word_tog;
    logic        word_tog_q;

    function automatic logic range_over(input logic signed [12:0] v);
        range_over = (v > `DADC_FULL_SCALE_POS) || (v < `DADC_FULL_SCALE_NEG);
    endfunction

    // Out of range inputs saturate, so a wrapped code never reaches the lanes.
    function automatic logic [11:0] to_offset(input logic signed [12:0] v);
        if (v > `DADC_FULL_SCALE_POS) begin
            to_offset = 12'hFFF;
        end else if (v < `DADC_FULL_SCALE_NEG) begin
            to_offset = 12'h000;
        end else begin
            to_offset = v[11:0] ^ 12'h800;
        end
    endfunction

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
            pin_s1  <= 1'b0;
            pin_s2  <= 1'b0;
        end else begin
            mode_s1 <= config_mode_select;
            mode_s2 <= mode_s1;
            pin_s1  <= par_stab_pin;
            pin_s2  <= pin_s1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clock_config_register  <= `DADC_CLK_CFG_RST;
            output_config_register <= `DADC_OUT_CFG_RST;
        end else if (reg_wr) begin
            if (reg_addr == `DADC_CLK_CFG_ADDR) begin
                clock_config_register <= {3'h0, reg_wdata[4:0]};
            end
            if (reg_addr == `DADC_OUT_CFG_ADDR) begin
                output_config_register <= {4'h0, reg_wdata[3], (reg_wdata[2:0] > 3'h6)
                                           ? 3'h6 : reg_wdata[2:0]};
            end
        end
    end

    assign stab_on = mode_s2 ? pin_s2 : clock_config_register[`DADC_CLK_STAB_BIT];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata          <= 8'h00;
            drive_current_code <= 4'h4;
            term_enable        <= 1'b0;
        end else begin
            term_enable <= output_config_register[`DADC_OUT_TERM_BIT];
            drive_current_code <= output_config_register[`DADC_OUT_TERM_BIT]
                ? {output_config_register[2:0], 1'b1}
                : {1'b0, output_config_register[2:0]};
            if (reg_rd) begin
                case (reg_addr)
                    `DADC_CLK_CFG_ADDR: reg_rdata <= clock_config_register;
                    `DADC_OUT_CFG_ADDR: reg_rdata <= output_config_register;
                    `DADC_STATUS_ADDR:  reg_rdata <= {6'h00, sticky_ovr, stab_on};
                    default:            reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // Phase and inversion cross as two-flop levels; a glitch is harmless.
    always_ff @(posedge sample_clock_pos or negedge rstn) begin
        if (!rstn) begin
            lk_s1      <= 2'h0;
            lk_s2      <= 2'h0;
            lk_stab_s1 <= 1'b0;
            lk_stab_s2 <= 1'b0;
            ovr_toggle <= 1'b0;
        end else begin
            lk_s1      <= clock_config_register[`DADC_CLK_PH_LSB +: 2];
            lk_s2      <= lk_s1;
            lk_stab_s1 <= stab_on;
            lk_stab_s2 <= lk_stab_s1;
            if (ovr_seen) begin
                ovr_toggle <= ~ovr_toggle;
            end
        end
    end

    assign lk_cfg = lk_stab_s2 ? lk_s2 : 2'h0;

    always_ff @(posedge sample_clock_pos or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `DADC_PIPE_CYCLES; i++) begin
                pipe[i] <= '0;
            end
        end else begin
            pipe[0] <= '{a: to_offset(ain_a), b: to_offset(ain_b),
                         ovr_a: range_over(ain_a), ovr_b: range_over(ain_b)};
            for (int i = 1; i < `DADC_PIPE_CYCLES; i++) begin
                pipe[i] <= pipe[i-1];
            end
        end
    end
    assign out_word = pipe[`DADC_PIPE_CYCLES-1];
    assign ovr_seen = out_word.ovr_a | out_word.ovr_b;

    // Marks each new output word so the lane clock can lock onto it.
    always_ff @(posedge sample_clock_pos or negedge rstn) begin
        if (!rstn) begin
            word_tog <= 1'b0;
        end else begin
            word_tog <= ~word_tog;
        end
    end

    // 50% duty from the fast phase clock
    always_ff @(posedge phase_clk or negedge rstn) begin
        if (!rstn) begin
            half       <= 1'b0;
            ph_sel     <= 2'h0;
            ph_delay   <= 3'h0;
            inv_s1     <= 1'b0;
            inv_s2     <= 1'b0;
            word_tog_q <= 1'b0;
        end else begin
            word_tog_q <= word_tog;
            // A new word restarts the low phase, so one clock period frames one sample.
            if (word_tog != word_tog_q) begin
                ph_sel <= 2'h1;
                half   <= 1'b0;
            end else begin
                ph_sel <= ph_sel + 2'h1;
                if (ph_sel == 2'h3) begin
                    half <= ~half;
                end
            end
            inv_s1   <= clock_config_register[`DADC_CLK_INV_BIT];
            inv_s2   <= inv_s1;
            ph_delay <= {ph_delay[1:0], half};
        end
    end

    always_ff @(posedge phase_clk or negedge rstn) begin
        if (!rstn) begin
            lanes <= '0;
        end else begin
            for (int p = 0; p < 6; p++) begin
                lanes.chan_a_ddr_pair[p] <= half ? out_word.a[2*p+1] : out_word.a[2*p];
                lanes.chan_b_ddr_pair[p] <= half ? out_word.b[2*p+1] : out_word.b[2*p];
            end
            lanes.range_exceeded_pair <= half ? out_word.ovr_b : out_word.ovr_a;
        end
    end

    always_ff @(posedge phase_clk or negedge rstn) begin
        if (!rstn) begin
            data_output_clock <= 1'b0;
        end else begin
            case (lk_cfg)
                2'h0:    data_output_clock <= half ^ inv_s2;
                2'h1:    data_output_clock <= ph_delay[0] ^ inv_s2;
                2'h2:    data_output_clock <= ph_delay[1] ^ inv_s2;
                2'h3:    data_output_clock <= ph_delay[2] ^ inv_s2;
                default: data_output_clock <= half ^ inv_s2;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ovr_t_s1   <= 1'b0;
            ovr_t_s2   <= 1'b0;
            ovr_t_s3   <= 1'b0;
            sticky_ovr <= 1'b0;
        end else begin
            ovr_t_s1 <= ovr_toggle;
            ovr_t_s2 <= ovr_t_s1;
            ovr_t_s3 <= ovr_t_s2;
            if (ovr_t_s2 != ovr_t_s3) begin
                sticky_ovr <= 1'b1;
            end else if (reg_rd && reg_addr == `DADC_STATUS_ADDR) begin
                sticky_ovr <= 1'b0;
            end
        end
    end
endmodule

/* design/dadc_pkg.sv */
/*
 * Types for the dual converter output block. Assumes nothing else.
 */
package dadc_pkg;
    typedef struct packed {
        logic [11:0] a;
        logic [11:0] b;
        logic        ovr_a;
        logic        ovr_b;
    } dadc_word_s;
    typedef struct packed {
        logic [5:0] chan_a_ddr_pair;
        logic [5:0] chan_b_ddr_pair;
        logic       range_exceeded_pair;
    } dadc_lanes_s;
    typedef enum logic [1:0] {
        DADC_PH_0   = 2'h0,
        DADC_PH_45  = 2'h1,
        DADC_PH_90  = 2'h2,
        DADC_PH_135 = 2'h3
    } dadc_phase_e;
endpackage

/* design/dadc_regs.svh */
/*
 * Offsets, field positions, reset values and timing counts for the dual
 * converter output block. Assumes a plain register port on core_clk.
 */
// What this block does
// - Six DDR pairs carry each 12-bit sample.
// - Even bit on clock low, odd high.
// - Data changes on both output clock edges.
// - Range flag high beyond either full scale.
// - Range flag pipelined like the data.
// - Flag pair: A low phase, B high.
// - Both channels sampled on one edge.
// - Drive current default 3.5mA, seven levels.
// - Termination bit doubles selected drive current.
// - Stabilizer regenerates 50% internal duty cycle; here it only enables the phase shift, and the 50% duty comes from phase_clk.
// - Stabilizer from register or chip-select pin.
// - Output clock delay 0/45/90/135 degrees.
// - Phase shift only with stabilizer on.
// - Separate bit inverts forwarded clock polarity.
// - Conversion starts on sample clock rising edge.
`ifndef DADC_REGS_SVH
`define DADC_REGS_SVH
`define DADC_CLK_CFG_ADDR   8'h02
`define DADC_OUT_CFG_ADDR   8'h03
`define DADC_STATUS_ADDR    8'h04
`define DADC_CLK_STAB_BIT   0
`define DADC_CLK_INV_BIT    1
`define DADC_CLK_PH_LSB     2
`define DADC_OUT_CUR_LSB    0
`define DADC_OUT_TERM_BIT   3
`define DADC_CLK_CFG_RST    8'h00
`define DADC_OUT_CFG_RST    8'h04
`define DADC_CUR_1P75       3'h0
`define DADC_CUR_3P5        3'h4
`define DADC_CUR_4P5        3'h6
`define DADC_PIPE_CYCLES    6
`define DADC_FULL_SCALE_POS 13'sh07FF
`define DADC_FULL_SCALE_NEG -13'sh0800
`endif

/* tb/dadc_out_properties.sv */
/* Register-side checker for dadc_out. Assumes core_clk domain ports. */
module dadc_out_properties (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] drive_current_code,
    input wire logic       term_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_wr_rd(logic [7:0] a);
        reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data without a read");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h02, 8'h03, 8'h04})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_reset_current: assert property ($rose(rstn) |-> drive_current_code == 4'h4)
        else $error("drive current not default");
    a_term_on: assert property (reg_wr && reg_addr == 8'h03 && reg_wdata[3]
        |-> ##[1:2] term_enable) else $error("termination not enabled");
    a_term_off: assert property (reg_wr && reg_addr == 8'h03 && !reg_wdata[3]
        |-> ##[1:2] !term_enable) else $error("termination not disabled");
    a_cur_clamped: assert property (!term_enable |-> drive_current_code <= 4'h6)
        else $error("drive code out of range");
    a_clk_readback: assert property (s_wr_rd(8'h02)
        |=> ((reg_rdata ^ $past(reg_wdata, 2)) & 8'h0F) == 8'h00) else $error("clock cfg readback");
    a_term_readback: assert property (s_wr_rd(8'h03)
        |=> ((reg_rdata ^ $past(reg_wdata, 2)) & 8'h08) == 8'h00) else $error("term readback");
    a_term_doubles: assert property (term_enable |-> drive_current_code[0])
        else $error("termination current not doubled");
endmodule
bind dadc_out dadc_out_properties u_props (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .drive_current_code, .term_enable);

/* tb/dadc_out_test.sv */
/* Bench for dadc_out. Assumes dadc_rx and the bound checker. */
module dadc_out_test
    import dadc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [12:0] a, b;
        logic [11:0] ea, eb;
        logic        oa, ob;
    } dadc_row_s;
    dadc_row_s rows [5] = '{'{13'h0000, 13'h0000, 12'h800, 12'h800, 1'h0, 1'h0},
        '{13'h07FF, 13'h1800, 12'hFFF, 12'h000, 1'h0, 1'h0},
        '{13'h0800, 13'h17FF, 12'hFFF, 12'h000, 1'h1, 1'h1},
        '{13'h1FFF, 13'h0001, 12'h7FF, 12'h801, 1'h0, 1'h0},
        '{13'h0155, 13'h1EAA, 12'h955, 12'h6AA, 1'h0, 1'h0}};
    logic core_clk = 0, rstn = 0, phase_clk = 0, sample_clock_pos = 0, inv = 0;
    logic [1:0] div = 2'h0;
    logic signed [12:0] ain_a = 0, ain_b = 0;
    logic config_mode_select = 0, par_stab_pin = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [3:0] drive_current_code;
    logic       term_enable, data_output_clock;
    dadc_lanes_s lanes;
    dadc_word_s  word;
    int fails = 0, checks_done = 0;
    always #5 core_clk = ~core_clk;
    // Eight phase cycles make one 15 ns sample period, one per 45 degree step.
    always #0.9375 phase_clk = ~phase_clk;
    always @(posedge phase_clk) begin
        div <= div + 2'h1;
        if (div == 2'h3) sample_clock_pos <= ~sample_clock_pos;
    end
    dadc_out DUT (.core_clk, .rstn, .sample_clock_pos, .phase_clk, .ain_a, .ain_b,
        .config_mode_select, .par_stab_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .lanes, .data_output_clock, .drive_current_code, .term_enable);
    dadc_rx u_rx (.phase_clk, .data_output_clock, .invert(inv), .lanes, .word);
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'h1) begin
            fails++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata === e, "read data");
        @(posedge core_clk);
    endtask
    task automatic run_row(input dadc_row_s r);
        @(posedge sample_clock_pos);
        ain_a <= r.a;
        ain_b <= r.b;
        repeat (12) @(posedge sample_clock_pos);
        chk(word === {r.ea, r.eb, r.oa, r.ob}, "lane word");
        @(posedge core_clk);
    endtask
    // Output clock level at the eight phase steps after a sample edge.
    task automatic clk_shape(input logic [7:0] e, input string m);
        logic [7:0] v;
        repeat (4) @(posedge sample_clock_pos);
        for (int j = 0; j < 8; j++) begin
            @(negedge phase_clk);
            v[j] = data_output_clock;
        end
        chk(v === e, m);
        @(posedge core_clk);
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'h1;
        @(posedge core_clk);
        chk(drive_current_code === 4'h4, "reset current");
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h04);
        rd(8'h10, 8'h00);
        $display("reset test done");
        foreach (rows[i]) run_row(rows[i]);
        rd(8'h04, 8'h02);
        rd(8'h04, 8'h00);
        $display("lane rows done");
        for (int i = 0; i < 7; i++) begin
            wr(8'h03, 8'(i));
            rd(8'h03, 8'(i));
            chk(drive_current_code === 4'(i), "drive code");
        end
        wr(8'h03, 8'h0F);
        rd(8'h03, 8'h0E);
        chk(drive_current_code === 4'hD && term_enable === 1'h1, "doubled");
        $display("drive test done");
        // Stabilizer off, so the phase field must be ignored while inversion still acts.
        wr(8'h02, 8'h0E);
        rd(8'h02, 8'h0E);
        inv <= 1'h1;
        run_row(rows[4]);
        clk_shape(8'h1E, "clock shape stabilizer off");
        config_mode_select <= 1'h1;
        par_stab_pin <= 1'h1;
        repeat (10) @(posedge core_clk);
        rd(8'h04, 8'h01);
        clk_shape(8'hF0, "clock shape 135 inverted");
        wr(8'h02, 8'h04);
        rd(8'h02, 8'h04);
        inv <= 1'h0;
        clk_shape(8'hC3, "clock shape 45");
        $display("clock test done");
        rstn <= 1'h0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'h1;
        @(posedge core_clk);
        chk(drive_current_code === 4'h4, "current after reset");
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h04);
        $display("mid-run reset done");
        close_out;
    end
endmodule

/* tb/dadc_rx.sv */
/* Receiver model rebuilding words from the DDR lanes. Assumes phase_clk. */
module dadc_rx
    import dadc_pkg::*;
(
    input  wire logic        phase_clk,
    input  wire logic        data_output_clock,
    input  wire logic        invert,
    input  wire dadc_lanes_s lanes,
    output dadc_word_s       word
);
    logic [5:0] lo_a;
    logic [5:0] lo_b;
    logic       lo_f;
    // Capture mid bit.
    // The falling phase edge keeps clear of lane updates.
    always @(negedge phase_clk) begin
        if (data_output_clock == invert) begin
            lo_a <= lanes.chan_a_ddr_pair;
            lo_b <= lanes.chan_b_ddr_pair;
            lo_f <= lanes.range_exceeded_pair;
        end else begin
            for (int p = 0; p < 6; p++) begin
                word.a[2*p]   <= lo_a[p];
                word.a[2*p+1] <= lanes.chan_a_ddr_pair[p];
                word.b[2*p]   <= lo_b[p];
                word.b[2*p+1] <= lanes.chan_b_ddr_pair[p];
            end
            word.ovr_a <= lo_f;
            word.ovr_b <= lanes.range_exceeded_pair;
        end
    end
endmodule
